// ---- testbench/sep_host.sv ----
// host controller model driving the three-wire serial link
`timescale 1ns/1ps
module sep_host (
  input wire logic i_clk,
  input wire logic i_serial_out,
  output sep_pkg::sep_pins_s o_pins
);
  import sep_pkg::*;
  int hold = 8;
  logic [15:0] rx = 16'h0000;
  initial begin
    o_pins = '0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // ****************************************
  // bit level
  // ****************************************
  // data is set while the clock is low so it is stable at the rise
  task automatic bit_io(input logic b);
    o_pins.sclk = 1'b0;
    o_pins.sdi = b;
    idle(hold);
    o_pins.sclk = 1'b1;
    idle(hold);
    rx = {rx[14:0], i_serial_out};
  endtask
  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      bit_io(v[i]);
    end
  endtask
  // ****************************************
  // framing
  // ****************************************
  task automatic select();
    o_pins.cs = 1'b1;
    idle(8);
  endtask
  // the data line is not held once released, so it flips
  task automatic release_cs(input int gap);
    o_pins.cs = 1'b0;
    o_pins.sclk = 1'b0;
    o_pins.sdi = ~o_pins.sdi;
    idle(gap);
  endtask
  task automatic instr(input logic [31:0] v, input int n);
    select();
    send(v, n);
    release_cs(40);
  endtask
endmodule // sep_host

// ---- testbench/testbench.sv ----
// self-checking bench for the serial eeprom program control block
`timescale 1ns/1ps
`include "sep_cfg.svh"
module testbench;
  import sep_pkg::*;
  localparam int unsigned WORD_CYC = 200;
  localparam int unsigned ERASE_ALL_CMD_CYC = 400;
  localparam int unsigned WRITE_ALL_CMD_CYC = 800;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic o_serial_out;
  logic o_serial_out_oe;
  // width select is a board strap, driven firmly at either level
  logic wide_sel = 1'b1;
  sep_pins_s pins;
  int n_fail = 0;
  int comparisons = 0;
  sep_host host (.i_clk(i_clk), .i_serial_out(o_serial_out), .o_pins(pins));
  sep_eeprom_ctl #(.WORD_CYC(WORD_CYC), .ERASE_ALL_CMD_CYC(ERASE_ALL_CMD_CYC), .WRITE_ALL_CMD_CYC(WRITE_ALL_CMD_CYC)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs(pins.cs), .i_sclk(pins.sclk),
    .i_serial_in(pins.sdi), .i_word_width_select(wide_sel),
    .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe));
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  // ****************************************
  // shared helpers
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [1:0] opc, input logic [6:0] a, input logic [15:0] d,
      input int aw, input int dw);
    logic [31:0] v;
    v = ((((32'h4 | 32'(opc)) << aw) | 32'(a)) << dw) | 32'(d);
    host.instr(v, 3 + aw + dw);
  endtask
  // select raised mid-cycle: low while busy, high after about cyc clocks
  task automatic poll(input int cyc);
    int n;
    n = 0;
    host.select();
    chk("status enable", 16'h0001, 16'(o_serial_out_oe));
    chk("busy level", 16'h0000, 16'(o_serial_out));
    while (o_serial_out !== 1'b1 && n < cyc) begin
      host.idle(1);
      n++;
    end
    chk("ready level", 16'h0001, 16'(o_serial_out));
    chk("cycle length", 16'h0001, 16'(n >= cyc - 50 && n <= cyc - 20));
    host.release_cs(40);
  endtask
  // no cycle running or select never raised during it: output stays off
  task automatic nopoll();
    host.select();
    chk("output off", 16'h0000, 16'(o_serial_out_oe));
    host.release_cs(40);
  endtask
  task automatic rd(input logic [6:0] a, input int aw, input int dw,
      output logic [15:0] w0, output logic [15:0] w1);
    logic [31:0] v;
    v = (32'h6 << aw) | 32'(a);
    host.select();
    host.send(v, 3 + aw);
    chk("dummy bit", 16'h0000, 16'(host.rx[0]));
    host.send(32'h0, dw);
    w0 = (dw == 16) ? host.rx : {8'h00, host.rx[7:0]};
    host.send(32'h0, dw);
    w1 = (dw == 16) ? host.rx : {8'h00, host.rx[7:0]};
    host.release_cs(40);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_refused();
    logic [15:0] w0, w1;
    host.send(32'h3F, 6);
    host.select();
    host.send(32'h0, 5);
    cmd(`SEP_OPC_WRITE, 7'h05, 16'h1234, 6, 16);
    nopoll();
    rd(7'h05, 6, 16, w0, w1);
    chk("read after refused write", 16'hFFFF, w0);
    $display("test refused done");
  endtask
  task automatic t_write();
    logic [15:0] w0, w1;
    cmd(`SEP_OPC_EXT, {1'b0, `SEP_EXT_ENABLE, 4'h0}, 16'h0003, 6, 2);
    host.hold = 20;
    cmd(`SEP_OPC_WRITE, 7'h05, 16'hA5C3, 6, 16);
    host.hold = 8;
    poll(WORD_CYC);
    cmd(`SEP_OPC_WRITE, 7'h06, 16'h0F0F, 6, 16);
    poll(WORD_CYC);
    rd(7'h05, 6, 16, w0, w1);
    chk("word 5", 16'hA5C3, w0);
    chk("word 6 sequential", 16'h0F0F, w1);
    $display("test write done");
  endtask
  task automatic t_erase();
    logic [15:0] w0, w1;
    cmd(`SEP_OPC_ERASE, 7'h05, 16'h0000, 6, 0);
    poll(WORD_CYC);
    rd(7'h05, 6, 16, w0, w1);
    chk("erased word", 16'hFFFF, w0);
    chk("neighbour kept", 16'h0F0F, w1);
    cmd(`SEP_OPC_ERASE, 7'h06, 16'h0000, 6, 0);
    host.idle(WORD_CYC);
    nopoll();
    rd(7'h06, 6, 16, w0, w1);
    chk("erased in standby", 16'hFFFF, w0);
    $display("test erase done");
  endtask
  task automatic t_all();
    logic [15:0] w0, w1;
    cmd(`SEP_OPC_EXT, {1'b0, `SEP_EXT_WRITE_ALL_CMD, 4'h0}, 16'h1E2D, 6, 16);
    poll(WRITE_ALL_CMD_CYC);
    rd(7'h00, 6, 16, w0, w1);
    chk("fill word 0", 16'h1E2D, w0);
    rd(7'h3F, 6, 16, w0, w1);
    chk("fill word 63", 16'h1E2D, w0);
    chk("wrap to word 0", 16'h1E2D, w1);
    cmd(`SEP_OPC_EXT, {1'b0, `SEP_EXT_ERASE_ALL_CMD, 4'h0}, 16'h0000, 6, 0);
    poll(ERASE_ALL_CMD_CYC);
    rd(7'h3F, 6, 16, w0, w1);
    chk("blank word 63", 16'hFFFF, w0);
    chk("blank word 0", 16'hFFFF, w1);
    $display("test all done");
  endtask
  task automatic t_disable();
    logic [15:0] w0, w1;
    cmd(`SEP_OPC_EXT, {1'b0, `SEP_EXT_DISABLE, 4'h0}, 16'h0000, 6, 0);
    cmd(`SEP_OPC_WRITE, 7'h09, 16'h1234, 6, 16);
    nopoll();
    cmd(`SEP_OPC_EXT, {1'b0, `SEP_EXT_WRITE_ALL_CMD, 4'h0}, 16'h0000, 6, 16);
    nopoll();
    rd(7'h09, 6, 16, w0, w1);
    chk("word 9 kept", 16'hFFFF, w0);
    $display("test disable done");
  endtask
  task automatic t_narrow();
    logic [15:0] w0, w1;
    wide_sel = 1'b0;
    host.idle(10);
    cmd(`SEP_OPC_EXT, {`SEP_EXT_ENABLE, 5'h00}, 16'h0000, 7, 0);
    cmd(`SEP_OPC_WRITE, 7'h07, 16'h005A, 7, 8);
    poll(WORD_CYC);
    rd(7'h07, 7, 8, w0, w1);
    chk("byte 7", 16'h005A, w0);
    chk("byte 8", 16'h00FF, w1);
    $display("test narrow done");
  endtask
  // reset in mid-run stands for a power cycle: the enable latch must come up clear
  task automatic t_reset();
    logic [15:0] w0, w1;
    i_rst = 1'b1;
    host.idle(5);
    i_rst = 1'b0;
    host.idle(8);
    cmd(`SEP_OPC_WRITE, 7'h09, 16'h0012, 7, 8);
    nopoll();
    rd(7'h09, 7, 8, w0, w1);
    chk("byte 9 after reset", 16'h00FF, w0);
    $display("test reset done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  // about 14400 clocks expected, so the limit leaves ample room
  initial begin
    repeat (40000) @(posedge i_clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    host.idle(8);
    t_refused();
    t_write();
    t_erase();
    t_all();
    t_disable();
    t_narrow();
    t_reset();
    tally_and_finish();
  end
endmodule // testbench

// ---- verilog/sep_cfg.svh ----
// constants for the serial eeprom program control block
`ifndef SEP_CFG_SVH
`define SEP_CFG_SVH
// ****************************************
// array shape and field lengths
// ****************************************
`define SEP_MEM_BYTES 128
`define SEP_IDX_W 7
`define SEP_ADDR_W_WIDE 5'h06
`define SEP_ADDR_W_NARROW 5'h07
`define SEP_DATA_W_WIDE 5'h10
`define SEP_DATA_W_NARROW 5'h08
`define SEP_ERASED_BYTE 8'hFF
`define SEP_ERASED_WORD 16'hFFFF
// ****************************************
// opcodes after the start bit
// ****************************************
`define SEP_OPC_EXT 2'h0
`define SEP_OPC_WRITE 2'h1
`define SEP_OPC_READ 2'h2
`define SEP_OPC_ERASE 2'h3
`define SEP_EXT_DISABLE 2'h0
`define SEP_EXT_WRITE_ALL_CMD 2'h1
`define SEP_EXT_ERASE_ALL_CMD 2'h2
`define SEP_EXT_ENABLE 2'h3
// ****************************************
// timing
// ****************************************
`define SEP_CLK_KHZ 125000
`define SEP_T_WORD_MS 4
`define SEP_T_ERASE_ALL_CMD_MS 8
`define SEP_T_WRITE_ALL_CMD_MS 16
`define SEP_TIMER_W 22
`endif

// ---- verilog/sep_eeprom_ctl.sv ----
// command decode, enable latch, array and ready/busy logic of a serial eeprom
// ****************************************
// Behaviour
// - power-up leaves programming disabled; erase and write refused until enabled.
// - enable latch stays set until a disable command or power loss.
// - reads run whatever the enable latch holds.
// - single erase sets every bit of the addressed word to one.
// - select falling after the last erase address bit starts a 4 ms cycle.
// - select raised during a cycle shows busy low, then ready high on output.
// - select falling after write data starts erase-then-program, 4 ms per word.
// - erase-all sets the whole array to ones in an 8 ms self-timed cycle.
// - write-all fills every word after implicit erase, 16 ms, needs enable.
// - select low means standby, but a started cycle still completes.
// - select low holds the instruction logic in reset and ignores the clock.
// - inputs sampled and output bits launched on rising serial clock edges.
// - serial clock may pause at either level and resume correctly.
// - before a start bit, clock edges change nothing.
// - after the last required bit, clock and input ignored until next start.
// - self-timed cycles need no serial clock.
// - output is high-impedance except read data or polled status.
// - width select high gives 16-bit words, low gives 8-bit words.
// - start bit is the first rising edge with select and input both high.
// - opcodes 10 read, 01 write, 11 erase, 00 extended by top address bits.
// - read sends a zero then the word msb first, then following words.
// ****************************************
`timescale 1ns/1ps
`include "sep_cfg.svh"
module sep_eeprom_ctl #(
  parameter int unsigned WORD_CYC = `SEP_T_WORD_MS * `SEP_CLK_KHZ,
  parameter int unsigned ERASE_ALL_CMD_CYC = `SEP_T_ERASE_ALL_CMD_MS * `SEP_CLK_KHZ,
  parameter int unsigned WRITE_ALL_CMD_CYC = `SEP_T_WRITE_ALL_CMD_MS * `SEP_CLK_KHZ
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs,
  input wire logic i_sclk,
  input wire logic i_serial_in,
  input wire logic i_word_width_select,
  output logic o_serial_out,
  output logic o_serial_out_oe
);
  import sep_pkg::*;

  // ****************************************
  // pin conditioning and edges
  // ****************************************
  sep_pins_s pins;
  logic cs_d_reg;
  logic sclk_d_reg;

  sep_pin_sync u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pins({i_cs, i_sclk, i_serial_in, i_word_width_select}),
    .o_pins(pins)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cs_d_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
    end else begin
      cs_d_reg <= pins.cs;
      sclk_d_reg <= pins.sclk;
    end
  end

  wire cs_fall = cs_d_reg && !pins.cs;
  wire cs_rise = !cs_d_reg && pins.cs;
  // only edges count, so any pause length at either level is harmless
  wire clk_rise = pins.cs && pins.sclk && !sclk_d_reg;
  wire sdi = pins.sdi;
  wire wide = pins.wide;
  wire [4:0] addr_len = wide ? `SEP_ADDR_W_WIDE : `SEP_ADDR_W_NARROW;
  wire [4:0] data_len = wide ? `SEP_DATA_W_WIDE : `SEP_DATA_W_NARROW;

  function automatic logic [6:0] byte_idx(input logic [6:0] a, input logic w,
                                          input logic lo);
    byte_idx = w ? {a[5:0], lo} : a;
  endfunction

  // ****************************************
  // instruction shifter
  // ****************************************
  sep_state_e state_reg;
  sep_state_e state_next;
  logic [15:0] sh_reg;
  logic [4:0] cnt_reg;
  logic [1:0] opc_reg;
  logic [6:0] addr_reg;
  logic [15:0] data_reg;
  sep_op_e pend_reg;
  logic en_reg;
  logic rd_oe_reg;
  logic rd_bit_reg;
  logic [15:0] rd_sh_reg;
  logic [7:0] mem_reg [0:`SEP_MEM_BYTES-1];

  wire [15:0] sh_next = {sh_reg[14:0], sdi};
  wire addr_last = (state_reg == SEP_ST_ADDR) && clk_rise && (cnt_reg == addr_len - 5'h01);
  wire data_last = (state_reg == SEP_ST_DATA) && clk_rise && (cnt_reg == data_len - 5'h01);
  wire rd_last = (state_reg == SEP_ST_READ) && clk_rise && (cnt_reg == data_len - 5'h01);
  wire [6:0] addr_new = wide ? {1'b0, sh_next[5:0]} : sh_next[6:0];
  wire [1:0] ext_sel = wide ? sh_next[5:4] : sh_next[6:5];
  wire [6:0] addr_inc = wide ? {1'b0, addr_reg[5:0] + 6'h01} : addr_reg + 7'h01;
  wire [6:0] rd_addr = (state_reg == SEP_ST_ADDR) ? addr_new : addr_inc;
  wire [7:0] rd_hi = mem_reg[byte_idx(rd_addr, wide, 1'b0)];
  wire [7:0] rd_lo = mem_reg[byte_idx(rd_addr, wide, 1'b1)];
  wire [15:0] rd_word = wide ? {rd_hi, rd_lo} : {rd_hi, 8'h00};
  wire is_read = opc_reg == `SEP_OPC_READ;
  wire is_ext = opc_reg == `SEP_OPC_EXT;
  wire cmd_en = addr_last && is_ext && (ext_sel == `SEP_EXT_ENABLE);
  wire cmd_dis = addr_last && is_ext && (ext_sel == `SEP_EXT_DISABLE);
  wire start_bit = (state_reg == SEP_ST_WAIT) && clk_rise && sdi;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SEP_ST_WAIT: if (start_bit) state_next = SEP_ST_OPC;
      SEP_ST_OPC: if (clk_rise && cnt_reg[0]) state_next = SEP_ST_ADDR;
      SEP_ST_ADDR: begin
        if (addr_last) begin
          if (is_read) begin
            state_next = SEP_ST_READ;
          end else if (opc_reg == `SEP_OPC_WRITE) begin
            state_next = SEP_ST_DATA;
          end else if (is_ext && ext_sel == `SEP_EXT_WRITE_ALL_CMD) begin
            state_next = SEP_ST_DATA;
          end else begin
            state_next = SEP_ST_DONE;
          end
        end
      end
      SEP_ST_DATA: if (data_last) state_next = SEP_ST_DONE;
      SEP_ST_READ: state_next = SEP_ST_READ;
      SEP_ST_DONE: state_next = SEP_ST_DONE;
      default: state_next = SEP_ST_WAIT;
    endcase
    if (!pins.cs) state_next = SEP_ST_WAIT;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= SEP_ST_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // field counter resets whenever a field closes; shift register too, except at the end of the opcode field
  always_ff @(posedge i_clk) begin
    if (i_rst || !pins.cs) begin
      cnt_reg <= 5'h00;
      sh_reg <= 16'h0000;
    end else if (start_bit || addr_last || data_last || rd_last) begin
      cnt_reg <= 5'h00;
      sh_reg <= 16'h0000;
    end else if (clk_rise && (state_reg == SEP_ST_OPC)) begin
      cnt_reg <= cnt_reg + 5'h01;
      sh_reg <= sh_next;
      if (cnt_reg[0]) begin
        cnt_reg <= 5'h00;
      end
    end else if (clk_rise && (state_reg != SEP_ST_WAIT) && (state_reg != SEP_ST_DONE)) begin
      cnt_reg <= cnt_reg + 5'h01;
      sh_reg <= sh_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      opc_reg <= 2'h0;
      addr_reg <= 7'h00;
      data_reg <= 16'h0000;
    end else begin
      if (clk_rise && (state_reg == SEP_ST_OPC) && cnt_reg[0]) opc_reg <= sh_next[1:0];
      if (addr_last) addr_reg <= addr_new;
      if (rd_last) addr_reg <= addr_inc;
      if (data_last) data_reg <= sh_next;
    end
  end

  // ****************************************
  // enable latch and pending operation
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      en_reg <= 1'b0;
    end else if (cmd_en) begin
      en_reg <= 1'b1;
    end else if (cmd_dis) begin
      en_reg <= 1'b0;
    end
  end

  sep_op_e pend_next;
  always_comb begin
    pend_next = SEP_OP_NONE;
    if (addr_last && opc_reg == `SEP_OPC_ERASE) pend_next = SEP_OP_ERASE;
    if (addr_last && is_ext && ext_sel == `SEP_EXT_ERASE_ALL_CMD) pend_next = SEP_OP_ERASE_ALL_CMD;
    if (data_last) pend_next = is_ext ? SEP_OP_WRITE_ALL_CMD : SEP_OP_WRITE;
  end

  // a command is only armed once every required bit is in
  always_ff @(posedge i_clk) begin
    if (i_rst || !pins.cs) begin
      pend_reg <= SEP_OP_NONE;
    end else if (pend_next != SEP_OP_NONE) begin
      pend_reg <= pend_next;
    end
  end

  // ****************************************
  // self-timed programming
  // ****************************************
  logic busy;
  wire try_launch = cs_fall && (pend_reg != SEP_OP_NONE) && !busy;
  wire launch = try_launch && en_reg;
  wire op_all = (pend_reg == SEP_OP_ERASE_ALL_CMD) || (pend_reg == SEP_OP_WRITE_ALL_CMD);
  wire op_erase = (pend_reg == SEP_OP_ERASE) || (pend_reg == SEP_OP_ERASE_ALL_CMD);
  wire [`SEP_TIMER_W-1:0] cyc_sel =
    (pend_reg == SEP_OP_ERASE_ALL_CMD) ? `SEP_TIMER_W'(ERASE_ALL_CMD_CYC) :
    (pend_reg == SEP_OP_WRITE_ALL_CMD) ? `SEP_TIMER_W'(WRITE_ALL_CMD_CYC) :
    `SEP_TIMER_W'(WORD_CYC);
  wire [6:0] idx_hi = byte_idx(addr_reg, wide, 1'b0);
  wire [6:0] idx_lo = byte_idx(addr_reg, wide, 1'b1);

  // cycle keeps running after select drops; standby follows its end
  sep_prog_timer u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(launch),
    .i_cycles(cyc_sel),
    .o_busy(busy)
  );

  // array contents are final at launch; erase-before-write is implicit
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < `SEP_MEM_BYTES; i++) begin
      if (i_rst) begin
        mem_reg[i] <= `SEP_ERASED_BYTE;
      end else if (launch && (op_all || 7'(i) == idx_hi || 7'(i) == idx_lo)) begin
        if (op_erase) begin
          mem_reg[i] <= `SEP_ERASED_BYTE;
        end else if (wide && !i[0]) begin
          mem_reg[i] <= data_reg[15:8];
        end else begin
          mem_reg[i] <= data_reg[7:0];
        end
      end
    end
  end

  // ****************************************
  // serial output: read data and polled status
  // ****************************************
  logic stat_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst || !pins.cs || start_bit) begin
      stat_reg <= 1'b0;
    end else if (cs_rise && busy) begin
      stat_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !pins.cs) begin
      rd_oe_reg <= 1'b0;
      rd_bit_reg <= 1'b1;
      rd_sh_reg <= 16'h0000;
    end else if (addr_last && is_read) begin
      rd_oe_reg <= 1'b1;
      rd_bit_reg <= 1'b0;
      rd_sh_reg <= rd_word;
    end else if (clk_rise && state_reg == SEP_ST_READ) begin
      rd_bit_reg <= rd_sh_reg[15];
      rd_sh_reg <= rd_last ? rd_word : {rd_sh_reg[14:0], 1'b0};
    end
  end

  wire so_next = stat_reg ? !busy : rd_bit_reg;
  wire oe_next = stat_reg || rd_oe_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_serial_out <= 1'b1;
      o_serial_out_oe <= 1'b0;
    end else begin
      o_serial_out <= so_next;
      o_serial_out_oe <= oe_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_read_addr;
    addr_last && is_read;
  endsequence
  sequence s_dummy_out;
    !rd_bit_reg ##1 (o_serial_out_oe && !o_serial_out);
  endsequence

  a_locked_no_busy: assert property (try_launch && !en_reg |=> !busy)
    else $error("programming started while disabled");
  a_locked_no_change: assert property (try_launch && !en_reg |=> $stable(mem_reg[idx_hi]))
    else $error("array changed while disabled");
  a_enable_sticky: assert property (en_reg && !cmd_dis |=> en_reg)
    else $error("enable latch dropped without disable");
  a_erase_ones: assert property (launch && op_erase |=> mem_reg[$past(idx_hi)] == 8'hFF)
    else $error("erased word not all ones");
  a_launch_busy: assert property (launch |=> busy [*2])
    else $error("no busy after select fall");
  a_status_busy: assert property (stat_reg && busy |=> o_serial_out_oe && !o_serial_out)
    else $error("status not shown low while busy");
  a_cs_low_reset: assert property (!pins.cs |=> state_reg == SEP_ST_WAIT)
    else $error("control logic not held in reset");
  a_wait_hold: assert property (state_reg == SEP_ST_WAIT && !start_bit |=> state_reg == SEP_ST_WAIT)
    else $error("state moved without start bit");
  a_done_ignore: assert property (state_reg == SEP_ST_DONE && pins.cs |=> $stable(en_reg))
    else $error("input acted on after last bit");
  a_hiz_default: assert property (!stat_reg && !rd_oe_reg |=> !o_serial_out_oe)
    else $error("output driven outside read or status");
  a_read_dummy: assert property (s_read_addr |=> s_dummy_out)
    else $error("read did not start with a zero bit");
endmodule // sep_eeprom_ctl

// ---- verilog/sep_pin_sync.sv ----
// three-stage synchroniser with agreement filter for the pin inputs
`timescale 1ns/1ps
module sep_pin_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire sep_pkg::sep_pins_s i_pins,
  output sep_pkg::sep_pins_s o_pins
);
  import sep_pkg::*;
  sep_pins_s s1_reg;
  sep_pins_s s2_reg;
  sep_pins_s s3_reg;
  sep_pins_s lvl_reg;
  wire sep_pins_s agree = ~(s2_reg ^ s3_reg);
  wire sep_pins_s lvl_next = (agree & s2_reg) | (~agree & lvl_reg);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      s3_reg <= 4'h0;
      lvl_reg <= 4'h0;
    end else begin
      s1_reg <= i_pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end
  assign o_pins = lvl_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // judged bit by bit: another pin may be mid-transition while this one settles
  a_sync_agree_only: assert property ($changed(lvl_reg) |->
      ((lvl_reg ^ $past(lvl_reg)) & $past(s2_reg ^ s3_reg)) == 4'h0)
    else $error("pin level moved without stage agreement");
endmodule // sep_pin_sync

// ---- verilog/sep_pkg.sv ----
// types shared by the serial eeprom program control block
package sep_pkg;
  typedef enum logic [5:0] {
    SEP_ST_WAIT = 6'h01,
    SEP_ST_OPC = 6'h02,
    SEP_ST_ADDR = 6'h04,
    SEP_ST_DATA = 6'h08,
    SEP_ST_READ = 6'h10,
    SEP_ST_DONE = 6'h20
  } sep_state_e;
  typedef enum logic [2:0] {
    SEP_OP_NONE = 3'h0,
    SEP_OP_ERASE = 3'h1,
    SEP_OP_WRITE = 3'h2,
    SEP_OP_ERASE_ALL_CMD = 3'h3,
    SEP_OP_WRITE_ALL_CMD = 3'h4
  } sep_op_e;
  typedef struct packed {
    logic cs;
    logic sclk;
    logic sdi;
    logic wide;
  } sep_pins_s;
endpackage

// ---- verilog/sep_prog_timer.sv ----
// self-timed programming cycle counter, runs on the system clock only
`timescale 1ns/1ps
`include "sep_cfg.svh"
module sep_prog_timer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [`SEP_TIMER_W-1:0] i_cycles,
  output logic o_busy
);
  import sep_pkg::*;
  logic [`SEP_TIMER_W-1:0] cnt_reg;
  logic busy_reg;
  wire last_w = busy_reg && (cnt_reg == {`SEP_TIMER_W{1'b0}});

  // needs no serial clock at all, so the host may stop clocking
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= {`SEP_TIMER_W{1'b0}};
      busy_reg <= 1'b0;
    end else if (i_start && !busy_reg) begin
      cnt_reg <= i_cycles - `SEP_TIMER_W'(1);
      busy_reg <= 1'b1;
    end else if (last_w) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - `SEP_TIMER_W'(1);
    end
  end
  assign o_busy = busy_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_timer_ends: assert property (last_w |=> !busy_reg)
    else $error("busy did not drop at end of count");
  a_timer_runs: assert property (busy_reg && !last_w |=>
      busy_reg && (cnt_reg == $past(cnt_reg) - `SEP_TIMER_W'(1)))
    else $error("busy dropped or count skipped before expiry");
endmodule // sep_prog_timer
